/* File: pkg/qdac_chan_if.sv */
// Purpose: command and state bundle between decoder and one channel
// Assumes: all signals on sys_clk
// Notes: write strobes are one-cycle pulses
`timescale 1ns/1ps
interface qdac_chan_if;
	import qdac_pkg::*;
	logic buf_wr;
	logic out_wr_new;
	logic out_wr_buf;
	logic init_go;
	qdac_word_t new_val;
	qdac_word_t init_val;
	qdac_word_t word;
	qdac_pd_t pd_mode;
	modport ctrl (output buf_wr, out_wr_new, out_wr_buf, init_go, new_val, init_val,
		input word, pd_mode);
	modport chan (input buf_wr, out_wr_new, out_wr_buf, init_go, new_val, init_val,
		output word, pd_mode);
endinterface : qdac_chan_if

/* File: pkg/qdac_params.svh */
// Purpose: constants for the quad converter command decoder
// Assumes: 24-bit frames, four channels of 18-bit registers
// Notes: included by the package and by the property module qdac_props
`ifndef QDAC_PARAMS_SVH
`define QDAC_PARAMS_SVH
`define QDAC_CHANNELS 4
`define QDAC_REG_BITS 18
`define QDAC_FRAME_BITS 24
`define QDAC_LAST_EDGE 5'h17
`define QDAC_LD_HI 21
`define QDAC_LD_LO 20
`define QDAC_SEL_HI 18
`define QDAC_SEL_LO 17
`define QDAC_PD_FLAG 16
`define QDAC_PD_HI 15
`define QDAC_PD_LO 14
`define QDAC_LD_STORE 2'h0
`define QDAC_LD_SINGLE 2'h1
`define QDAC_LD_SIMUL 2'h2
`define QDAC_LD_BCAST 2'h3
`define QDAC_ZERO_SCALE 18'h00000
`define QDAC_MID_SCALE 18'h08000
`define QDAC_INIT_WAIT 2'h3
`endif

/* File: pkg/qdac_pkg.sv */
// Purpose: shared types of the quad converter command decoder
// Assumes: constants come from qdac_params.svh
// Notes: power-down modes in order active, hiz, 1k, 100k
`include "qdac_params.svh"
package qdac_pkg;
	typedef logic [`QDAC_REG_BITS-1:0] qdac_word_t;
	typedef logic [`QDAC_CHANNELS-1:0][`QDAC_REG_BITS-1:0] qdac_bank_t;
	typedef enum logic [1:0] {qdac_pd_active, qdac_pd_hiz, qdac_pd_r1k, qdac_pd_r100k} qdac_pd_t;
	typedef logic [`QDAC_CHANNELS-1:0][1:0] qdac_pd_bank_t;
	typedef enum logic [1:0] {st_idle, st_shift, st_locked} qdac_state_t;
endpackage : qdac_pkg

/* File: test/qdac_host_model.sv */
// Purpose: host side of the three-wire command link
// Assumes: link clock period 200 ns, idle high
// Notes: link clock stands still between frames
`timescale 1ns/1ps
module qdac_host_model (
	output logic frame_sync_n_out, // frame select
	output logic sclk_out, // link clock
	output logic sdata_out // serial data
);
	initial begin
		frame_sync_n_out = 1'b1;
		sclk_out = 1'b1;
		sdata_out = 1'b0;
	end
	task automatic send(input logic [23:0] word, input int nbits);
		#7;
		frame_sync_n_out = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			sdata_out = word[23 - i];
			#100;
			sclk_out = 1'b0;
			#100;
			sclk_out = 1'b1;
		end
		#100;
		frame_sync_n_out = 1'b1;
		sdata_out = ~sdata_out;
		#400;
	endtask : send
endmodule : qdac_host_model

/* File: test/qdac_props.sv */
// Purpose: port checks of the command decoder
// Assumes: link pins much slower than sys_clk_in
// Notes: bound from the bench top
`timescale 1ns/1ps
`include "qdac_params.svh"
module qdac_props (
	input wire logic sys_clk_in, // clock
	input wire logic arst_n_in, // reset
	input wire logic clear_n_in, // clear
	input wire logic reset_level_select_in, // level
	input wire logic frame_sync_n_in, // frame
	input wire logic sclk_in, // link clock
	input qdac_pkg::qdac_bank_t ch_word_out, // words
	input qdac_pkg::qdac_pd_bank_t ch_pd_mode_out, // modes
	input wire logic frame_done_out, // done
	input wire logic frame_abort_out, // abort
	input wire logic ready_out // ready
);
	import qdac_pkg::*;
	logic rst_ok;
	logic [4:0] fall_cnt_r;
	assign rst_ok = arst_n_in & clear_n_in;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_ok);
	// Falls of the link clock seen since the frame began
	always_ff @(posedge sys_clk_in or negedge rst_ok) begin
		if (!rst_ok) begin
			fall_cnt_r <= 5'h00;
		end else if ($fell(frame_sync_n_in)) begin
			fall_cnt_r <= 5'h00;
		end else if (!frame_sync_n_in && $fell(sclk_in) && fall_cnt_r != 5'h1f) begin
			fall_cnt_r <= fall_cnt_r + 5'h01;
		end
	end
	function automatic qdac_pd_t pd_of(logic [1:0] c);
		return c == 2'h0 ? qdac_pd_active : c == 2'h1 ? qdac_pd_r1k :
			c == 2'h2 ? qdac_pd_r100k : qdac_pd_hiz;
	endfunction : pd_of
	sequence last_bit_s;
		!frame_sync_n_in && $fell(sclk_in) && fall_cnt_r == 5'h17;
	endsequence
	sequence early_end_s;
		$rose(frame_sync_n_in) && fall_cnt_r != 5'h00 && fall_cnt_r < 5'h18;
	endsequence
	done_pulse_a: assert property (frame_done_out |=> !frame_done_out)
		else $error("done pulse too long");
	done_count_a: assert property (frame_done_out |-> fall_cnt_r == 5'h18)
		else $error("done without 24 falls");
	done_bound_a: assert property (last_bit_s |-> ##[2:6] frame_done_out)
		else $error("no decode after last fall");
	abort_bound_a: assert property (early_end_s |-> ##[2:6] frame_abort_out)
		else $error("short frame not discarded");
	abort_quiet_a: assert property (frame_abort_out |-> $stable(ch_word_out))
		else $error("discarded frame changed words");
	ready_delay_a: assert property ($rose(rst_ok) |-> !ready_out [*3] ##1 ready_out)
		else $error("ready timing wrong");
	ready_level_a: assert property ($rose(ready_out) |-> ch_word_out ==
		{4{reset_level_select_in ? `QDAC_MID_SCALE : `QDAC_ZERO_SCALE}})
		else $error("reset level wrong");
	for (genvar i = 0; i < 4; i++) begin : g_pd
		pd_map_a: assert property (ch_pd_mode_out[i] == pd_of(ch_word_out[i][17:16]))
			else $error("mode does not match word");
	end
endmodule : qdac_props

/* File: test/qdac_top_tb.sv */
// Purpose: self-checking bench of the command decoder
// Assumes: host model drives the link pins
// Notes: expected words in exp_w, compared under msk
`timescale 1ns/1ps
module qdac_top_tb;
	import qdac_pkg::*;
	logic sys_clk_in, arst_n_in, clear_n_in, rsel, strobe, fs_n, sclk, sdata, done, abort, ready;
	qdac_bank_t words, exp_w, msk;
	qdac_pd_bank_t pds;
	int failures = 0, compares = 0, done_n = 0, abort_n = 0;
	qdac_top u_qdac_top (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .clear_n_in(clear_n_in),
		.reset_level_select_in(rsel), .frame_sync_n_in(fs_n), .sclk_in(sclk), .sdata_in(sdata),
		.async_load_strobe_in(strobe), .ch_word_out(words), .ch_pd_mode_out(pds),
		.frame_done_out(done), .frame_abort_out(abort), .ready_out(ready));
	qdac_host_model u_qdac_host_model (.frame_sync_n_out(fs_n), .sclk_out(sclk), .sdata_out(sdata));
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		done_n <= done_n + int'(done === 1'b1);
		abort_n <= abort_n + int'(abort === 1'b1);
	end
	function automatic logic [23:0] fw(logic [1:0] ld, logic [1:0] sel, logic pd, logic [15:0] d);
		return {2'h0, ld, 1'b0, sel, pd, d};
	endfunction : fw
	function automatic logic [1:0] pd_of(logic [1:0] c);
		return c == 2'h3 ? 2'h1 : (c == 2'h0 ? 2'h0 : c + 2'h1);
	endfunction : pd_of
	task automatic complete_run();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic fail(input string m);
		failures++;
		$display("[ERR] %0t %s", $time, m);
	endtask : fail
	task automatic chk_bank();
		compares++;
		for (int i = 0; i < 4; i++) begin
			if ((words[i] & msk[i]) !== (exp_w[i] & msk[i]) || pds[i] !== pd_of(exp_w[i][17:16]))
				fail($sformatf("channel %0d word or mode", i));
		end
	endtask : chk_bank
	task automatic chk_cnt(input int got, input int want);
		compares++;
		if (got !== want)
			fail("pulse count");
	endtask : chk_cnt
	task automatic frame(input logic [23:0] w);
		int d;
		d = done_n;
		u_qdac_host_model.send(w, 24);
		chk_cnt(done_n, d + 1);
	endtask : frame
	task automatic do_reset(input logic lvl, input logic clr);
		@(posedge sys_clk_in);
		rsel <= lvl;
		if (clr)
			clear_n_in <= 1'b0;
		else
			arst_n_in <= 1'b0;
		repeat (12) @(posedge sys_clk_in);
		arst_n_in <= 1'b1;
		clear_n_in <= 1'b1;
		for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge sys_clk_in);
		if (ready !== 1'b1) begin
			fail("ready timeout");
			complete_run();
		end else begin
			exp_w = {4{lvl ? 18'h08000 : 18'h00000}};
			msk = '1;
			chk_bank();
		end
	endtask : do_reset
	task automatic t_store();
		frame(fw(2'h0, 2'h1, 1'b0, 16'hbeef));
		frame(fw(2'h0, 2'h0, 1'b1, 16'hbfff));
		chk_bank();
		frame(fw(2'h1, 2'h2, 1'b0, 16'h1234) | 24'h080000);
		exp_w[2] = 18'h01234;
		chk_bank();
	endtask : t_store
	task automatic t_simul();
		frame(fw(2'h2, 2'h3, 1'b1, 16'h4abc));
		exp_w = {{2'h1, 16'h0}, 18'h01234, 18'h0beef, {2'h2, 16'h0}};
		msk = {18'h30000, {2{18'h3ffff}}, 18'h30000};
		chk_bank();
		frame(fw(2'h1, 2'h1, 1'b1, 16'hc0a5));
		exp_w[1] = 18'h30000;
		msk[1] = 18'h30000;
		chk_bank();
	endtask : t_simul
	task automatic t_abort();
		int d;
		d = abort_n;
		u_qdac_host_model.send(fw(2'h1, 2'h0, 1'b0, 16'h5555), 12);
		chk_cnt(abort_n, d + 1);
		chk_bank();
	endtask : t_abort
	task automatic t_bcast();
		frame(fw(2'h3, 2'h2, 1'b0, 16'h0a5a));
		exp_w = {4{18'h00a5a}};
		msk = '1;
		chk_bank();
		frame(fw(2'h0, 2'h2, 1'b0, 16'h7777));
		frame(fw(2'h3, 2'h1, 1'b1, 16'hffff));
		exp_w[2] = 18'h07777;
		chk_bank();
	endtask : t_bcast
	task automatic t_async_load_strobe();
		frame(fw(2'h0, 2'h0, 1'b0, 16'h4444));
		chk_bank();
		@(posedge sys_clk_in);
		strobe <= 1'b1;
		repeat (6) @(posedge sys_clk_in);
		strobe <= 1'b0;
		exp_w[0] = 18'h04444;
		chk_bank();
	endtask : t_async_load_strobe
	initial begin
		arst_n_in = 1'b0;
		clear_n_in = 1'b1;
		rsel = 1'b1;
		strobe = 1'b0;
		do_reset(1'b1, 1'b0);
		t_store();
		t_simul();
		t_abort();
		t_bcast();
		t_async_load_strobe();
		do_reset(1'b0, 1'b1);
		complete_run();
	end
endmodule : qdac_top_tb
bind qdac_top qdac_props u_qdac_props (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
	.clear_n_in(clear_n_in), .reset_level_select_in(reset_level_select_in),
	.frame_sync_n_in(frame_sync_n_in), .sclk_in(sclk_in), .ch_word_out(ch_word_out),
	.ch_pd_mode_out(ch_pd_mode_out), .frame_done_out(frame_done_out),
	.frame_abort_out(frame_abort_out), .ready_out(ready_out));

/* File: verilog/qdac_chan.sv */
// Purpose: one channel: buffer word and output word with power-down decode
// Assumes: strobes from the decoder, one clock domain
// Notes: init wins over frame writes
`timescale 1ns/1ps
module qdac_chan (
	input wire logic sys_clk_in, // 40 MHz clock
	input wire logic rst_n_in, // combined async reset
	qdac_chan_if.chan cif // decoder side
);
	import qdac_pkg::*;
	qdac_word_t buf_r;
	qdac_word_t out_r;
	qdac_word_t out_nxt;
	qdac_pd_t pd_r;
	qdac_pd_t pd_nxt;

	always_comb begin
		out_nxt = out_r;
		if (cif.init_go) begin
			out_nxt = cif.init_val;
		end else if (cif.out_wr_new) begin
			out_nxt = cif.new_val;
		end else if (cif.out_wr_buf) begin
			out_nxt = buf_r;
		end
	end

	// Mode follows the output word only, never the buffer
	always_comb begin
		case (out_nxt[`QDAC_REG_BITS-1 -: 2])
			2'h1: pd_nxt = qdac_pd_r1k;
			2'h2: pd_nxt = qdac_pd_r100k;
			2'h3: pd_nxt = qdac_pd_hiz;
			default: pd_nxt = qdac_pd_active;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			buf_r <= `QDAC_ZERO_SCALE;
		end else if (cif.init_go) begin
			buf_r <= cif.init_val;
		end else if (cif.buf_wr) begin
			buf_r <= cif.new_val;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_r <= `QDAC_ZERO_SCALE;
			pd_r <= qdac_pd_active;
		end else begin
			out_r <= out_nxt;
			pd_r <= pd_nxt;
		end
	end

	assign cif.word = out_r;
	assign cif.pd_mode = pd_r;
endmodule : qdac_chan

/* File: verilog/qdac_top.sv */
// Purpose: serial frame receiver and command decoder for four channels
// Assumes: serial pins are asynchronous to sys_clk and much slower
// Notes: pins other than arst_n_in and clear_n_in pass two flip-flops before any use
`timescale 1ns/1ps
module qdac_top (
	input wire logic sys_clk_in, // 40 MHz clock
	input wire logic arst_n_in, // power-on reset, active low
	input wire logic clear_n_in, // asynchronous clear pin, active low
	input wire logic reset_level_select_in, // 0 zero-scale, 1 midscale
	input wire logic frame_sync_n_in, // frame select, active low
	input wire logic sclk_in, // serial clock pin
	input wire logic sdata_in, // serial data pin
	input wire logic async_load_strobe_in, // rising edge loads all outputs
	output qdac_pkg::qdac_bank_t ch_word_out, // output words, channel 0..3
	output qdac_pkg::qdac_pd_bank_t ch_pd_mode_out, // power-down mode per channel
	output logic frame_done_out, // pulse: complete frame decoded
	output logic frame_abort_out, // pulse: frame discarded
	output logic ready_out // reset level applied, frames accepted
);
	import qdac_pkg::*;

	// Clear acts at once, same as power-on
	logic rst_n;
	assign rst_n = arst_n_in & clear_n_in;

	// Two-stage synchronisers
	logic [4:0] meta_r;
	logic [4:0] sync_r;
	logic [4:0] pin_vec;
	assign pin_vec = {reset_level_select_in, async_load_strobe_in, sdata_in, sclk_in,
		frame_sync_n_in};

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 5'h03;
			sync_r <= 5'h03;
		end else begin
			meta_r <= pin_vec;
			sync_r <= meta_r;
		end
	end

	logic fsync_s;
	logic sclk_s;
	logic sdata_s;
	logic async_load_strobe_s;
	logic reset_level_select_s;
	assign fsync_s = sync_r[0];
	assign sclk_s = sync_r[1];
	assign sdata_s = sync_r[2];
	assign async_load_strobe_s = sync_r[3];
	assign reset_level_select_s = sync_r[4];

	// Edge detection on synchronised levels
	logic fsync_d_r;
	logic sclk_d_r;
	logic async_load_strobe_d_r;

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			fsync_d_r <= 1'h1;
			sclk_d_r <= 1'h1;
			async_load_strobe_d_r <= 1'h0;
		end else begin
			fsync_d_r <= fsync_s;
			sclk_d_r <= sclk_s;
			async_load_strobe_d_r <= async_load_strobe_s;
		end
	end

	logic fsync_fall;
	logic fsync_rise;
	logic sclk_fall;
	logic async_load_strobe_rise;
	assign fsync_fall = fsync_d_r & ~fsync_s;
	assign fsync_rise = ~fsync_d_r & fsync_s;
	assign sclk_fall = sclk_d_r & ~sclk_s;
	assign async_load_strobe_rise = ~async_load_strobe_d_r & async_load_strobe_s;

	// Reset level applied a few cycles after release, once the select is settled
	logic [1:0] init_cnt_r;
	logic ready_r;
	logic init_go;
	assign init_go = (init_cnt_r == 2'h1);

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			init_cnt_r <= `QDAC_INIT_WAIT;
		end else if (init_cnt_r != 2'h0) begin
			init_cnt_r <= init_cnt_r - 2'h1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ready_r <= 1'h0;
		end else if (init_go) begin
			ready_r <= 1'h1;
		end
	end

	qdac_word_t init_val;
	assign init_val = reset_level_select_s ? `QDAC_MID_SCALE : `QDAC_ZERO_SCALE;

	// Frame state machine
	qdac_state_t state_r;
	logic [`QDAC_FRAME_BITS-1:0] input_shift_word_r;
	logic [4:0] edge_cnt_r;
	logic last_edge;
	logic frame_fire;
	logic frame_abort;
	logic [`QDAC_FRAME_BITS-1:0] full_word;

	assign last_edge = (edge_cnt_r == `QDAC_LAST_EDGE);
	assign frame_fire = (state_r == st_shift) && !fsync_rise && sclk_fall && last_edge;
	assign frame_abort = (state_r == st_shift) && fsync_rise;
	assign full_word = {input_shift_word_r[`QDAC_FRAME_BITS-2:0], sdata_s};

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= st_idle;
		end else begin
			case (state_r)
				st_idle: begin
					if (ready_r && fsync_fall) begin
						state_r <= st_shift;
					end
				end
				st_shift: begin
					if (fsync_rise) begin
						state_r <= st_idle;
					end else if (sclk_fall && last_edge) begin
						state_r <= st_locked;
					end
				end
				st_locked: begin
					if (fsync_fall) begin
						state_r <= st_shift;
					end
				end
				default: state_r <= st_idle;
			endcase
		end
	end

	// Shift register clears at frame start and on abort, freezes when locked
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			input_shift_word_r <= '0;
			edge_cnt_r <= 5'h00;
		end else if (fsync_fall || frame_abort) begin
			input_shift_word_r <= '0;
			edge_cnt_r <= 5'h00;
		end else if (state_r == st_shift && sclk_fall) begin
			input_shift_word_r <= full_word;
			edge_cnt_r <= edge_cnt_r + 5'h01;
		end
	end

	// Field decode; bit 19 is never looked at
	logic [1:0] ld_mode;
	logic [1:0] ch_sel;
	logic power_down_flag;
	logic bcast_write;
	qdac_word_t new_val;

	assign ld_mode = {full_word[`QDAC_LD_HI], full_word[`QDAC_LD_LO]};
	assign ch_sel = {full_word[`QDAC_SEL_HI], full_word[`QDAC_SEL_LO]};
	assign power_down_flag = full_word[`QDAC_PD_FLAG];
	assign bcast_write = full_word[`QDAC_SEL_HI];
	// Power-down code replaces data and drops bits 13:0
	assign new_val = power_down_flag ?
		{full_word[`QDAC_PD_HI], full_word[`QDAC_PD_LO], 16'h0000} :
		{2'h0, full_word[15:0]};

	// Per-channel strobes
	qdac_chan_if ch_if [`QDAC_CHANNELS] ();

	genvar gi;
	generate
		for (gi = 0; gi < `QDAC_CHANNELS; gi++) begin : g_ch
			logic hit;
			logic bw;
			logic ow_new;
			logic ow_buf;
			assign hit = (ch_sel == 2'(gi));

			always_comb begin
				bw = 1'h0;
				ow_new = 1'h0;
				ow_buf = async_load_strobe_rise;
				if (frame_fire) begin
					case (ld_mode)
						`QDAC_LD_STORE: begin
							bw = hit;
						end
						`QDAC_LD_SINGLE: begin
							bw = hit;
							ow_new = hit;
						end
						`QDAC_LD_SIMUL: begin
							bw = hit;
							ow_new = hit;
							ow_buf = 1'h1;
						end
						default: begin
							bw = bcast_write;
							ow_new = bcast_write;
							ow_buf = 1'h1;
						end
					endcase
				end
			end

			assign ch_if[gi].buf_wr = bw;
			assign ch_if[gi].out_wr_new = ow_new;
			assign ch_if[gi].out_wr_buf = ow_buf;
			assign ch_if[gi].init_go = init_go;
			assign ch_if[gi].new_val = new_val;
			assign ch_if[gi].init_val = init_val;

			qdac_chan u_chan (
				.sys_clk_in(sys_clk_in),
				.rst_n_in(rst_n),
				.cif(ch_if[gi])
			);

			assign ch_word_out[gi] = ch_if[gi].word;
			assign ch_pd_mode_out[gi] = ch_if[gi].pd_mode;
		end
	endgenerate

	// Status pulses
	logic frame_done_r;
	logic frame_abort_r;

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			frame_done_r <= 1'h0;
			frame_abort_r <= 1'h0;
		end else begin
			frame_done_r <= frame_fire;
			frame_abort_r <= frame_abort;
		end
	end

	assign frame_done_out = frame_done_r;
	assign frame_abort_out = frame_abort_r;
	assign ready_out = ready_r;
endmodule : qdac_top
